// ==== esr_pkg.sv ====
// Constants for the exposure status reporting bank.
// Assumes the register port uses the printed register numbers as addresses.
`default_nettype none
package esr_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_PIXEL_COUNT = 8'hb8;
    localparam logic [7:0] OFF_AVERAGE_LEVEL = 8'hba;
    localparam logic [7:0] OFF_LOOP_EXPOSURE = 8'hbb;
    localparam logic [7:0] OFF_LOOP_GAIN = 8'hbc;
    localparam logic [7:0] OFF_STEP_MULT = 8'hd0;
    localparam logic [7:0] OFF_ARRAY_RESET = 8'hd1;
    localparam logic [7:0] OFF_APPLIED_EXP = 8'hd2;
    localparam logic [7:0] OFF_SECOND_SLOPE = 8'hd3;
    localparam logic [7:0] OFF_THIRD_SLOPE = 8'hd4;
    localparam logic [7:0] OFF_ANALOG_GAINS = 8'hd5;
    localparam logic [7:0] OFF_FINE_SLOPES = 8'hd6;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int AVG_W = 10;
    localparam int LG_MUX_LSB = 0;
    localparam int LG_AFE_LSB = 2;
    localparam int LG_DIG_LSB = 4;
    localparam int AG_MUX_LSB = 0;
    localparam int AG_AFE_LSB = 5;
    localparam int FINE_W = 12;
    // ------------------------------------------------------------
    // Reset values and report selects
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0] SEL_FINE_GAIN = 2'h0;
    localparam logic [1:0] SEL_DUAL_SLOPE = 2'h1;
    localparam logic [1:0] SEL_TRIPLE_SLOPE = 2'h2;
endpackage
`default_nettype wire

// ==== esr_status_bank.sv ====
// Exposure status register bank: loop results and applied-frame values.
// Assumes loop and sequencer logic share i_core_clk and give one-cycle pulses.
`default_nettype none
module esr_status_bank #(
    parameter int DATA_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic i_aec_stat_valid,
    input wire logic [15:0] i_aec_pixel_count,
    input wire logic [9:0] i_aec_average,
    input wire logic i_aec_request,
    input wire logic i_frame_end,
    input wire logic [15:0] i_aec_exposure,
    input wire logic [1:0] i_aec_mux_gain,
    input wire logic [1:0] i_aec_afe_gain,
    input wire logic [11:0] i_aec_dig_gain,
    input wire logic i_seq_effect,
    input wire logic i_global_shutter,
    input wire logic [15:0] i_seq_step_mult,
    input wire logic [15:0] i_seq_reset_len,
    input wire logic [15:0] i_seq_exposure,
    input wire logic [15:0] i_seq_second_slope_exposure,
    input wire logic [15:0] i_seq_third_slope_exposure,
    input wire logic [4:0] i_seq_mux_gain,
    input wire logic [7:0] i_seq_afe_gain,
    input wire logic [11:0] i_seq_applied_fine_gain,
    input wire logic [11:0] i_seq_dual_slope_cfg,
    input wire logic [11:0] i_seq_triple_slope_cfg,
    input wire logic [1:0] i_report_sel,
    output logic [15:0] o_reg_rdata_ff,
    output logic o_reg_ack_ff
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DATA_W != 16) begin : g_bad_width
        $error("esr_status_bank supports DATA_W of 16 only");
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] stat_pix_ff;
    logic [9:0] stat_avg_ff;
    logic [15:0] loop_exp_ff;
    logic [15:0] loop_gain_ff;
    logic pend_valid_ff;
    logic [15:0] pend_exp_ff;
    logic [15:0] pend_gain_ff;
    logic [15:0] app_mult_ff;
    logic [15:0] app_rst_ff;
    logic [15:0] app_exp_ff;
    logic [15:0] app_ds_exp_ff;
    logic [15:0] app_ts_exp_ff;
    logic [15:0] app_gains_ff;
    logic [11:0] app_fine_ff;
    logic [11:0] app_ds_cfg_ff;
    logic [11:0] app_ts_cfg_ff;

    // ------------------------------------------------------------
    // Loop result path
    // ------------------------------------------------------------
    wire logic [15:0] req_gain = {i_aec_dig_gain, i_aec_afe_gain, i_aec_mux_gain};
    wire logic req_now = i_ce && i_aec_request;
    wire logic end_now = i_ce && i_frame_end;
    // Request in the frame-end cycle itself commits directly, no frame lost
    wire logic commit = end_now && (i_aec_request || pend_valid_ff);
    wire logic [15:0] nxt_loop_exp = i_aec_request ? i_aec_exposure : pend_exp_ff;
    wire logic [15:0] nxt_loop_gain = i_aec_request ? req_gain : pend_gain_ff;
    wire logic nxt_pend_valid = end_now ? 1'b0 : (req_now ? 1'b1 : pend_valid_ff);
    wire logic stat_now = i_ce && i_aec_stat_valid;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pend_valid_ff <= 1'b0;
            pend_exp_ff <= esr_pkg::RST_WORD;
            pend_gain_ff <= esr_pkg::RST_WORD;
        end else begin
            pend_valid_ff <= nxt_pend_valid;
            if (req_now) begin
                pend_exp_ff <= i_aec_exposure;
                pend_gain_ff <= req_gain;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            loop_exp_ff <= esr_pkg::RST_WORD;
            loop_gain_ff <= esr_pkg::RST_WORD;
        end else if (commit) begin
            loop_exp_ff <= nxt_loop_exp;
            loop_gain_ff <= nxt_loop_gain;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stat_pix_ff <= esr_pkg::RST_WORD;
            stat_avg_ff <= esr_pkg::RST_WORD[9:0];
        end else if (stat_now) begin
            stat_pix_ff <= i_aec_pixel_count;
            stat_avg_ff <= i_aec_average;
        end
    end

    // ------------------------------------------------------------
    // Applied-frame path
    // ------------------------------------------------------------
    // Sequencer only reports a value once the readout uses it, so it lags the loop
    wire logic eff_now = i_ce && i_seq_effect;
    wire logic gs_eff = eff_now && i_global_shutter;
    wire logic [15:0] nxt_app_gains = {3'h0, i_seq_afe_gain, i_seq_mux_gain};

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            app_mult_ff <= esr_pkg::RST_WORD;
            app_rst_ff <= esr_pkg::RST_WORD;
        end else if (gs_eff) begin
            app_mult_ff <= i_seq_step_mult;
            app_rst_ff <= i_seq_reset_len;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            app_exp_ff <= esr_pkg::RST_WORD;
            app_ds_exp_ff <= esr_pkg::RST_WORD;
            app_ts_exp_ff <= esr_pkg::RST_WORD;
            app_gains_ff <= esr_pkg::RST_WORD;
            app_fine_ff <= esr_pkg::RST_WORD[11:0];
            app_ds_cfg_ff <= esr_pkg::RST_WORD[11:0];
            app_ts_cfg_ff <= esr_pkg::RST_WORD[11:0];
        end else if (eff_now) begin
            app_exp_ff <= i_seq_exposure;
            app_ds_exp_ff <= i_seq_second_slope_exposure;
            app_ts_exp_ff <= i_seq_third_slope_exposure;
            app_gains_ff <= nxt_app_gains;
            app_fine_ff <= i_seq_applied_fine_gain;
            app_ds_cfg_ff <= i_seq_dual_slope_cfg;
            app_ts_cfg_ff <= i_seq_triple_slope_cfg;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Three fields share one address; a plain select picks which one shows
    wire logic [11:0] shared_field = (i_report_sel == esr_pkg::SEL_DUAL_SLOPE) ? app_ds_cfg_ff :
        (i_report_sel == esr_pkg::SEL_TRIPLE_SLOPE) ? app_ts_cfg_ff : app_fine_ff;

    function automatic logic [15:0] read_mux(input logic [7:0] addr);
        logic [15:0] v;
        v = 16'h0000;
        case (addr)
            esr_pkg::OFF_PIXEL_COUNT: v = stat_pix_ff;
            esr_pkg::OFF_AVERAGE_LEVEL: v = {6'h00, stat_avg_ff};
            esr_pkg::OFF_LOOP_EXPOSURE: v = loop_exp_ff;
            esr_pkg::OFF_LOOP_GAIN: v = loop_gain_ff;
            esr_pkg::OFF_STEP_MULT: v = app_mult_ff;
            esr_pkg::OFF_ARRAY_RESET: v = app_rst_ff;
            esr_pkg::OFF_APPLIED_EXP: v = app_exp_ff;
            esr_pkg::OFF_SECOND_SLOPE: v = app_ds_exp_ff;
            esr_pkg::OFF_THIRD_SLOPE: v = app_ts_exp_ff;
            esr_pkg::OFF_ANALOG_GAINS: v = app_gains_ff;
            esr_pkg::OFF_FINE_SLOPES: v = {4'h0, shared_field};
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // Process form so the mux also follows the stored words it reads
    logic [15:0] rd_word;
    always_comb begin
        rd_word = read_mux(i_reg_addr);
    end
    wire logic rd_now = i_ce && i_reg_rd;
    wire logic nxt_ack = i_ce ? (i_reg_rd || i_reg_wr) : o_reg_ack_ff;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata_ff <= esr_pkg::RST_WORD;
            o_reg_ack_ff <= 1'b0;
        end else begin
            o_reg_ack_ff <= nxt_ack;
            if (rd_now) begin
                o_reg_rdata_ff <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_req_only;
        i_ce && i_aec_request && !i_frame_end;
    endsequence
    sequence s_end_only;
        i_ce && i_frame_end && !i_aec_request;
    endsequence

    AST_LOOP_EXP_AT_END: assert property ($changed(loop_exp_ff) |-> $past(end_now))
        else $error("loop exposure changed outside frame end");
    AST_LOOP_GAIN_AT_END: assert property ($changed(loop_gain_ff) |-> $past(end_now))
        else $error("loop gain changed outside frame end");
    AST_DIRECT_COMMIT: assert property (i_ce && i_frame_end && i_aec_request |=>
        loop_gain_ff == $past(req_gain) && loop_exp_ff == $past(i_aec_exposure))
        else $error("request at frame end not committed");
    AST_PENDING_COMMIT: assert property (s_req_only ##1 s_end_only |=>
        loop_gain_ff == $past(req_gain, 2))
        else $error("pending request not committed at frame end");
    AST_APPLIED_ON_EFFECT: assert property ($changed(app_exp_ff) |-> $past(eff_now))
        else $error("applied exposure changed without effect");
    AST_MULT_GLOBAL_ONLY: assert property ($changed(app_mult_ff) |-> $past(gs_eff))
        else $error("step multiplier changed outside global shutter effect");
    AST_RESET_LEN_GLOBAL_ONLY: assert property ($changed(app_rst_ff) |-> $past(gs_eff))
        else $error("reset length changed outside global shutter effect");
    AST_SLOPE_ON_EFFECT: assert property ($changed(app_ds_exp_ff) || $changed(app_ts_cfg_ff)
        |-> $past(eff_now))
        else $error("slope status changed without effect");
    AST_READ_PIXELS: assert property (rd_now && i_reg_addr == esr_pkg::OFF_PIXEL_COUNT
        |=> o_reg_rdata_ff == $past(stat_pix_ff) && o_reg_ack_ff)
        else $error("pixel count read wrong");
    AST_READ_AVERAGE: assert property (rd_now && i_reg_addr == esr_pkg::OFF_AVERAGE_LEVEL
        |=> o_reg_rdata_ff[15:10] == 6'h00 && o_reg_rdata_ff[9:0] == $past(stat_avg_ff))
        else $error("average read wrong");
    AST_GAINS_LAYOUT: assert property (eff_now |=>
        app_gains_ff == {3'h0, $past(i_seq_afe_gain), $past(i_seq_mux_gain)})
        else $error("applied gain layout wrong");
    AST_WRITE_IGNORED: assert property (i_ce && i_reg_wr && !i_reg_rd
        |=> $stable(o_reg_rdata_ff) && o_reg_ack_ff)
        else $error("write disturbed read data");
    AST_FREEZE: assert property (!i_ce |=> $stable(o_reg_rdata_ff) && $stable(loop_exp_ff)
        && $stable(app_exp_ff) && $stable(o_reg_ack_ff))
        else $error("state moved with clock enable low");

    // ------------------------------------------------------------
    // Load, hold, read-back and ack checks
    // ------------------------------------------------------------
    AST_STATS_LOAD: assert property (stat_now |=> stat_pix_ff == $past(i_aec_pixel_count)
        && stat_avg_ff == $past(i_aec_average))
        else $error("statistics not loaded");
    AST_STATS_HOLD: assert property ($changed(stat_pix_ff) |-> $past(stat_now))
        else $error("pixel count changed without statistics strobe");
    AST_LOOP_HOLD: assert property (end_now && !i_aec_request && !pend_valid_ff |=>
        $stable(loop_exp_ff) && $stable(loop_gain_ff))
        else $error("frame end with nothing pending changed loop status");
    AST_GS_LOAD: assert property (gs_eff |=> app_mult_ff == $past(i_seq_step_mult)
        && app_rst_ff == $past(i_seq_reset_len))
        else $error("global shutter values not loaded");
    AST_APPLIED_LOAD: assert property (eff_now |=> app_exp_ff == $past(i_seq_exposure)
        && app_ds_exp_ff == $past(i_seq_second_slope_exposure))
        else $error("applied exposure not loaded");
    AST_THIRD_SLOPE_LOAD: assert property (eff_now |=>
        app_ts_exp_ff == $past(i_seq_third_slope_exposure))
        else $error("third slope exposure not loaded");
    AST_FINE_LOAD: assert property (eff_now |=>
        app_fine_ff == $past(i_seq_applied_fine_gain))
        else $error("applied fine gain not loaded");
    AST_SLOPE_CFG_LOAD: assert property (eff_now |=>
        app_ds_cfg_ff == $past(i_seq_dual_slope_cfg)
        && app_ts_cfg_ff == $past(i_seq_triple_slope_cfg))
        else $error("slope configurations not loaded");
    AST_READ_LOOP_EXP: assert property (rd_now && i_reg_addr == esr_pkg::OFF_LOOP_EXPOSURE
        |=> o_reg_rdata_ff == $past(loop_exp_ff))
        else $error("loop exposure read wrong");
    AST_READ_LOOP_GAIN: assert property (rd_now && i_reg_addr == esr_pkg::OFF_LOOP_GAIN
        |=> o_reg_rdata_ff == $past(loop_gain_ff))
        else $error("loop gain read wrong");
    AST_READ_ANALOG: assert property (rd_now && i_reg_addr == esr_pkg::OFF_ANALOG_GAINS
        |=> o_reg_rdata_ff == $past(app_gains_ff))
        else $error("applied analog gains read wrong");
    AST_READ_SHARED: assert property (rd_now && i_reg_addr == esr_pkg::OFF_FINE_SLOPES
        |=> o_reg_rdata_ff == {4'h0, $past(shared_field)})
        else $error("shared field read wrong");
    AST_UNMAPPED_ZERO: assert property (rd_now && i_reg_addr == 8'hb9
        |=> o_reg_rdata_ff == 16'h0000)
        else $error("gap in the map did not read zero");
    AST_ACK_ONE_CYCLE: assert property (i_ce && !i_reg_rd && !i_reg_wr |=> !o_reg_ack_ff)
        else $error("ack without a request");
endmodule // esr_status_bank
`default_nettype wire

// ==== esr_host_model.sv ====
// Host model for the status bank register port: one-cycle read or write strobes.
// Assumes the bank takes a request on a rising edge and acks one cycle later.
`default_nettype none
module esr_host_model (
    input wire logic i_core_clk,
    output logic o_reg_rd,
    output logic o_reg_wr,
    output logic [7:0] o_reg_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Register port driver
    // ------------------------------------------------------------
    initial begin
        o_reg_rd = 1'b0;
        o_reg_wr = 1'b0;
        o_reg_addr = 8'h00;
    end
    // Taken on a single edge, so the strobe drops right after it
    task automatic xfer(input logic wr, input logic [7:0] addr);
        @(negedge i_core_clk);
        o_reg_rd = ~wr;
        o_reg_wr = wr;
        o_reg_addr = addr;
        @(negedge i_core_clk);
        o_reg_rd = 1'b0;
        o_reg_wr = 1'b0;
        // Idle address moves so a stale decode cannot pass
        o_reg_addr = ~addr;
    endtask
endmodule // esr_host_model
`default_nettype wire

// ==== tb_exposure_status_reporting.sv ====
// Self-checking bench for the exposure status register bank.
// Assumes the host model drives the register port and the bench drives the rest.
`default_nettype none
module tb_exposure_status_reporting;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus and expected state
    // ------------------------------------------------------------
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_ce = 1'b1;
    logic i_global_shutter = 1'b0;
    logic [3:0] strb = 4'h0;
    logic i_aec_stat_valid, i_aec_request, i_frame_end, i_seq_effect;
    logic i_reg_rd, i_reg_wr, o_reg_ack_ff;
    logic [7:0] i_reg_addr;
    logic [15:0] o_reg_rdata_ff, last, pend_e, pend_g;
    logic [15:0] i_aec_pixel_count = 16'h0, i_aec_exposure = 16'h0, i_seq_step_mult = 16'h0;
    logic [15:0] i_seq_reset_len = 16'h0, i_seq_exposure = 16'h0;
    logic [15:0] i_seq_second_slope_exposure = 16'h0, i_seq_third_slope_exposure = 16'h0;
    logic [11:0] i_aec_dig_gain = 12'h0, i_seq_applied_fine_gain = 12'h0;
    logic [11:0] i_seq_dual_slope_cfg = 12'h0, i_seq_triple_slope_cfg = 12'h0;
    logic [9:0] i_aec_average = 10'h0;
    logic [7:0] i_seq_afe_gain = 8'h0;
    logic [4:0] i_seq_mux_gain = 5'h0;
    logic [1:0] i_aec_mux_gain = 2'h0, i_aec_afe_gain = 2'h0, i_report_sel = 2'h0;
    logic [15:0] exp_reg [0:255];
    logic [15:0] exp_q [$];
    int num_errors = 0;
    int total_checks = 0;
    int seed = 32'h7adb;
    localparam logic [7:0] REGS [0:12] = '{8'hb8, 8'hba, 8'hbb, 8'hbc, 8'hd0, 8'hd1,
        8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hb9, 8'h00};
    assign {i_seq_effect, i_frame_end, i_aec_request, i_aec_stat_valid} = strb;
    always #12.5 i_core_clk = ~i_core_clk;

    esr_host_model u_host (.i_core_clk(i_core_clk), .o_reg_rd(i_reg_rd),
        .o_reg_wr(i_reg_wr), .o_reg_addr(i_reg_addr));
    esr_status_bank #(.DATA_W(16)) DUT (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_ce(i_ce), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
        .i_aec_stat_valid(i_aec_stat_valid), .i_aec_pixel_count(i_aec_pixel_count),
        .i_aec_average(i_aec_average), .i_aec_request(i_aec_request),
        .i_frame_end(i_frame_end), .i_aec_exposure(i_aec_exposure),
        .i_aec_mux_gain(i_aec_mux_gain), .i_aec_afe_gain(i_aec_afe_gain),
        .i_aec_dig_gain(i_aec_dig_gain), .i_seq_effect(i_seq_effect),
        .i_global_shutter(i_global_shutter), .i_seq_step_mult(i_seq_step_mult),
        .i_seq_reset_len(i_seq_reset_len), .i_seq_exposure(i_seq_exposure),
        .i_seq_second_slope_exposure(i_seq_second_slope_exposure),
        .i_seq_third_slope_exposure(i_seq_third_slope_exposure),
        .i_seq_mux_gain(i_seq_mux_gain), .i_seq_afe_gain(i_seq_afe_gain),
        .i_seq_applied_fine_gain(i_seq_applied_fine_gain),
        .i_seq_dual_slope_cfg(i_seq_dual_slope_cfg),
        .i_seq_triple_slope_cfg(i_seq_triple_slope_cfg), .i_report_sel(i_report_sel),
        .o_reg_rdata_ff(o_reg_rdata_ff), .o_reg_ack_ff(o_reg_ack_ff));

    // ------------------------------------------------------------
    // Tasks and result monitor
    // ------------------------------------------------------------
    task results;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always @(negedge i_core_clk) begin
        if (o_reg_ack_ff === 1'b1) begin
            if (exp_q.size() == 0) chk(o_reg_rdata_ff, 16'hffff);
            else chk(o_reg_rdata_ff, exp_q.pop_front());
        end
    end
    // Writes ack with the last read data still standing
    task xfer(input logic wr, input logic [7:0] a);
        if (!wr) last = exp_reg[a];
        exp_q.push_back(last);
        u_host.xfer(wr, a);
        for (int n = 0; n < 4 && exp_q.size() != 0; n++) @(negedge i_core_clk);
        if (exp_q.size() != 0) begin
            num_errors++;
            results();
        end
    endtask
    task pulse(input logic [3:0] s);
        @(negedge i_core_clk);
        strb = s;
        @(negedge i_core_clk);
        strb = 4'h0;
    endtask
    task pulse2(input logic [3:0] s, input logic [3:0] t);
        @(negedge i_core_clk);
        strb = s;
        @(negedge i_core_clk);
        strb = t;
        @(negedge i_core_clk);
        strb = 4'h0;
    endtask
    task aec_new;
        {i_aec_exposure, i_aec_dig_gain} = 28'($random(seed));
        {i_aec_afe_gain, i_aec_mux_gain} = 4'($random(seed));
        pend_e = i_aec_exposure;
        pend_g = {i_aec_dig_gain, i_aec_afe_gain, i_aec_mux_gain};
    endtask
    task commit;
        exp_reg[8'hbb] = pend_e;
        exp_reg[8'hbc] = pend_g;
    endtask
    task seq_new(input logic gs);
        {i_seq_step_mult, i_seq_reset_len} = $random(seed);
        {i_seq_exposure, i_seq_second_slope_exposure} = $random(seed);
        {i_seq_third_slope_exposure, i_seq_afe_gain, i_seq_mux_gain} = 29'($random(seed));
        {i_seq_applied_fine_gain, i_seq_dual_slope_cfg} = 24'($random(seed));
        i_seq_triple_slope_cfg = 12'($random(seed));
        i_global_shutter = gs;
        pulse(4'h8);
        if (gs) {exp_reg[8'hd0], exp_reg[8'hd1]} = {i_seq_step_mult, i_seq_reset_len};
        {exp_reg[8'hd2], exp_reg[8'hd3]} = {i_seq_exposure, i_seq_second_slope_exposure};
        exp_reg[8'hd4] = i_seq_third_slope_exposure;
        exp_reg[8'hd5] = {3'h0, i_seq_afe_gain, i_seq_mux_gain};
    endtask
    task rd6(input logic [1:0] sel);
        i_report_sel = sel;
        exp_reg[8'hd6] = {4'h0, sel == 2'h1 ? i_seq_dual_slope_cfg :
            sel == 2'h2 ? i_seq_triple_slope_cfg : i_seq_applied_fine_gain};
        xfer(1'b0, 8'hd6);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        for (int k = 0; k < 256; k++) exp_reg[k] = 16'h0000;
        last = 16'h0000;
        repeat (20) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        foreach (REGS[k]) xfer(1'b0, REGS[k]);
        foreach (REGS[k]) xfer(1'b1, REGS[k]);
        {i_aec_pixel_count, i_aec_average} = 26'($random(seed));
        pulse(4'h1);
        {exp_reg[8'hb8], exp_reg[8'hba]} = {i_aec_pixel_count, 6'h0, i_aec_average};
        xfer(1'b0, 8'hb8);
        xfer(1'b0, 8'hba);
        aec_new();
        pulse(4'h2);
        xfer(1'b0, 8'hbb);
        aec_new();
        pulse(4'h2);
        pulse(4'h4);
        commit();
        xfer(1'b0, 8'hbb);
        xfer(1'b0, 8'hbc);
        xfer(1'b0, 8'hd2);
        pulse(4'h4);
        xfer(1'b0, 8'hbc);
        aec_new();
        pulse(4'h6);
        commit();
        xfer(1'b0, 8'hbc);
        aec_new();
        pulse2(4'h2, 4'h4);
        commit();
        xfer(1'b0, 8'hbb);
        xfer(1'b0, 8'hbc);
        for (int g = 0; g < 2; g++) begin
            seq_new(g[0]);
            for (int k = 4; k < 10; k++) xfer(1'b0, REGS[k]);
            for (int s = 0; s < 4; s++) rd6(s[1:0]);
            xfer(1'b0, 8'hbb);
        end
        // Let the last ack drain, or a frozen ack would stand high
        @(negedge i_core_clk);
        i_ce = 1'b0;
        i_seq_exposure = ~i_seq_exposure;
        u_host.xfer(1'b0, 8'hd2);
        pulse(4'h8);
        i_ce = 1'b1;
        xfer(1'b0, 8'hd2);
        foreach (REGS[k]) xfer(1'b1, REGS[k]);
        foreach (REGS[k]) xfer(1'b0, REGS[k]);
        results();
    end
endmodule // tb_exposure_status_reporting
`default_nettype wire
